// file: alu_ops_top.v
// subtract / swap / xor datapath with avalon-mm register access
`timescale 1ns/1ns
`include "alu_ops_regs.vh"

module alu_ops_top #(
	parameter FILE_DEPTH = 128
) (
	// clock and reset
	input  wire        clk,
	input  wire        resetn,
	// avalon-mm slave
	input  wire [7:0]  address,
	input  wire        read,
	input  wire        write,
	input  wire [31:0] writedata,
	output reg  [31:0] readdata,
	output wire        waitrequest,
	// state view
	output reg  [7:0]  acc_r,
	output reg         carry_flag_r,
	output reg         digit_carry_flag_r,
	output reg         zero_flag_r
);

	// ==========================================
	// bus handshake states
	// every access waits one cycle, then is answered and committed
	localparam [1:0] BUS_IDLE   = 2'h1;
	localparam [1:0] BUS_ANSWER = 2'h2;

	// ==========================================
	// storage
	reg [7:0]  file_mem [0:FILE_DEPTH-1];
	reg [1:0]  bus_state_r;
	reg [1:0]  bus_state_nxt;
	reg [7:0]  acc_nxt;
	reg        carry_flag_nxt;
	reg        digit_carry_flag_nxt;
	reg        zero_flag_nxt;
	reg [31:0] readdata_nxt;
	reg        file_we;
	reg [6:0]  file_waddr;
	reg [7:0]  file_wdata;
	integer    i;

	// ==========================================
	// bus qualifiers
	wire       answer     = bus_state_r[1];
	wire       pending    = read | write;
	// writes and instructions land only at the edge where waitrequest is low
	wire       wr_commit  = write & answer;
	// read data is taken one edge early so it stands when waitrequest drops
	wire       rd_capture = read & ~answer;

	// ==========================================
	// decode of a control write (an instruction)
	wire       exec     = wr_commit & (address == `REG_CTRL);
	wire [1:0] opcode   = writedata[`CTRL_OPCODE_MSB:`CTRL_OPCODE_LSB];
	wire       dest     = writedata[`CTRL_DEST_BIT];
	wire [6:0] faddr    = writedata[`CTRL_FADDR_MSB:`CTRL_FADDR_LSB];
	wire [7:0] literal  = writedata[`CTRL_LIT_MSB:`CTRL_LIT_LSB];
	wire [7:0] file_val = file_mem[faddr];

	wire [7:0] result;
	wire       carry_out;
	wire       digit_carry_out;
	wire       carry_we;
	wire       digit_carry_we;
	wire       zero_we;

	alu_ops_core alu_ops_core_inst (
		.opcode          (opcode),
		.acc             (acc_r),
		.file_val        (file_val),
		.literal         (literal),
		.result          (result),
		.carry_out       (carry_out),
		.digit_carry_out (digit_carry_out),
		.carry_we        (carry_we),
		.digit_carry_we  (digit_carry_we),
		.zero_we         (zero_we)
	);

	// literal xor always lands in the accumulator, whatever dest says
	wire to_file = dest & (opcode != `OP_XOR_LIT);

	// the file array fills the upper half of the byte map
	function is_file_addr;
		input [7:0] a;
		begin
			is_file_addr = a[7];
		end
	endfunction

	// combinational, so the answer comes exactly one cycle after the request
	assign waitrequest = pending & ~answer;

	// ==========================================
	// bus handshake next state
	// a request dropped in its answer cycle still moves on: the master must hold it
	always @* begin
		bus_state_nxt = bus_state_r;
		case (bus_state_r)
			BUS_IDLE: begin
				if (pending)
					bus_state_nxt = BUS_ANSWER;
			end
			BUS_ANSWER: begin
				bus_state_nxt = BUS_IDLE;
			end
			default: begin
				bus_state_nxt = BUS_IDLE;
			end
		endcase
	end

	// ==========================================
	// accumulator and flags next value
	// a bus load of acc or status is plain, no flag logic runs
	always @* begin
		acc_nxt              = acc_r;
		carry_flag_nxt       = carry_flag_r;
		digit_carry_flag_nxt = digit_carry_flag_r;
		zero_flag_nxt        = zero_flag_r;
		if (exec) begin
			if (!to_file)
				acc_nxt = result;
			if (carry_we)
				carry_flag_nxt = carry_out;
			if (digit_carry_we)
				digit_carry_flag_nxt = digit_carry_out;
			if (zero_we)
				zero_flag_nxt = (result == 8'h00);
		end else if (wr_commit) begin
			if (address == `REG_ACC)
				acc_nxt = writedata[7:0];
			if (address == `REG_STATUS) begin
				carry_flag_nxt       = writedata[`ST_CARRY];
				digit_carry_flag_nxt = writedata[`ST_DIGIT_CARRY];
				zero_flag_nxt        = writedata[`ST_ZERO];
			end
		end
	end

	// ==========================================
	// read data next value
	// unmapped addresses and the control word read back as zero
	// read data holds between reads, so a late look still finds it
	always @* begin
		readdata_nxt = readdata;
		if (rd_capture) begin
			if (address == `REG_ACC)
				readdata_nxt = {24'h000000, acc_r};
			else if (address == `REG_STATUS)
				readdata_nxt = {29'h00000000, zero_flag_r, digit_carry_flag_r, carry_flag_r};
			else if (is_file_addr(address))
				readdata_nxt = {24'h000000, file_mem[address[6:0]]};
			else
				readdata_nxt = 32'h00000000;
		end
	end

	// ==========================================
	// file array write port
	// an instruction and a file load never meet: they use different addresses
	always @* begin
		file_we    = 1'b0;
		file_waddr = faddr;
		file_wdata = result;
		if (exec & to_file) begin
			file_we    = 1'b1;
			file_waddr = faddr;
			file_wdata = result;
		end else if (wr_commit & is_file_addr(address)) begin
			file_we    = 1'b1;
			file_waddr = address[6:0];
			file_wdata = writedata[7:0];
		end
	end

	// ==========================================
	// registers
	// acc, flags, bus state and read data in one block keep their reset values together; the file array resets below
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			bus_state_r        <= BUS_IDLE;
			acc_r              <= `ACC_RESET;
			carry_flag_r       <= 1'b0;
			digit_carry_flag_r <= 1'b0;
			zero_flag_r        <= 1'b0;
			readdata           <= 32'h00000000;
		end else begin
			bus_state_r        <= bus_state_nxt;
			acc_r              <= acc_nxt;
			carry_flag_r       <= carry_flag_nxt;
			digit_carry_flag_r <= digit_carry_flag_nxt;
			zero_flag_r        <= zero_flag_nxt;
			readdata           <= readdata_nxt;
		end
	end

	// ==========================================
	// file register array
	// the whole array clears on reset, at the cost of a wide reset fan-out
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			for (i = 0; i < FILE_DEPTH; i = i + 1)
				file_mem[i] <= 8'h00;
		end else if (file_we) begin
			file_mem[file_waddr] <= file_wdata;
		end
	end

endmodule // alu_ops_top

// file: alu_ops_regs.vh
// constants for the subtract, swap and xor datapath
`ifndef ALU_OPS_REGS_VH
`define ALU_OPS_REGS_VH

// ==========================================
// register bus offsets (byte addresses)
`define REG_CTRL      8'h00
`define REG_ACC       8'h04
`define REG_STATUS    8'h08
`define REG_FILE_BASE 8'h80

// ==========================================
// control word fields
`define CTRL_OPCODE_LSB 0
`define CTRL_OPCODE_MSB 1
`define CTRL_DEST_BIT   2
`define CTRL_FADDR_LSB  8
`define CTRL_FADDR_MSB  14
`define CTRL_LIT_LSB    16
`define CTRL_LIT_MSB    23

// ==========================================
// opcodes
`define OP_SUB_FILE 2'h0
`define OP_SWAP     2'h1
`define OP_XOR_LIT  2'h2
`define OP_XOR_FILE 2'h3

// ==========================================
// status bits
`define ST_CARRY       0
`define ST_DIGIT_CARRY 1
`define ST_ZERO        2

// ==========================================
// reset values
`define ACC_RESET    8'h00
`define STATUS_RESET 3'h0

`endif

// file: alu_ops_core.v
// combinational result and flag unit
`timescale 1ns/1ns
`include "alu_ops_regs.vh"

module alu_ops_core (
	// operands
	input  wire [1:0] opcode,
	input  wire [7:0] acc,
	input  wire [7:0] file_val,
	input  wire [7:0] literal,
	// results
	output reg  [7:0] result,
	output reg        carry_out,
	output reg        digit_carry_out,
	output reg        carry_we,
	output reg        digit_carry_we,
	output reg        zero_we
);

	reg [8:0] diff;
	reg [4:0] ndiff;

	always @* begin
		diff      = {1'b0, file_val} + {1'b0, ~acc} + 9'h001;
		ndiff     = {1'b0, file_val[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
		result          = 8'h00;
		carry_out       = 1'b0;
		digit_carry_out = 1'b0;
		carry_we        = 1'b0;
		digit_carry_we  = 1'b0;
		zero_we         = 1'b0;
		case (opcode)
			`OP_SUB_FILE: begin
				result          = diff[7:0];
				carry_out       = diff[8];
				digit_carry_out = ndiff[4];
				carry_we        = 1'b1;
				digit_carry_we  = 1'b1;
				zero_we         = 1'b1;
			end
			`OP_SWAP: begin
				result = {file_val[3:0], file_val[7:4]};
			end
			`OP_XOR_LIT: begin
				result  = acc ^ literal;
				zero_we = 1'b1;
			end
			`OP_XOR_FILE: begin
				result  = acc ^ file_val;
				zero_we = 1'b1;
			end
			default: begin
				result = 8'h00;
			end
		endcase
	end

endmodule // alu_ops_core

// file: alu_ops_properties.sv
// checker for the alu datapath ports
`timescale 1ns/1ns
`include "alu_ops_regs.vh"
module alu_ops_properties #(
	parameter FILE_DEPTH = 128
) (
	// clock and reset
	input wire        clk,
	input wire        resetn,
	// bus
	input wire [7:0]  address,
	input wire        write,
	input wire [31:0] writedata,
	input wire        waitrequest,
	// state
	input wire [7:0]  acc_r,
	input wire        carry_flag_r,
	input wire        digit_carry_flag_r,
	input wire        zero_flag_r
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	wire       ex  = write && !waitrequest && address == `REG_CTRL;
	wire [1:0] op  = writedata[1:0];
	wire       dst = writedata[2] && op != `OP_XOR_LIT;
	wire [7:0] lit = writedata[23:16];
	xor_lit_acc_a: assert property (ex && op == `OP_XOR_LIT |=> acc_r == ($past(acc_r) ^ $past(lit)))
		else $error("literal xor result wrong");
	zero_track_a: assert property (ex && op != `OP_SWAP && !dst |=> zero_flag_r == (acc_r == 8'h00))
		else $error("zero flag wrong");
	xor_keeps_carry_a: assert property (ex && op[1] |=> $stable(carry_flag_r) && $stable(digit_carry_flag_r))
		else $error("xor changed carry");
	swap_keeps_flags_a: assert property (ex && op == `OP_SWAP |=> $stable({carry_flag_r, digit_carry_flag_r, zero_flag_r}))
		else $error("swap changed a flag");
	file_dest_a: assert property (ex && dst |=> $stable(acc_r))
		else $error("file destination touched acc");
	sub_zero_carry_a: assert property (ex && op == `OP_SUB_FILE |=> !zero_flag_r || carry_flag_r && digit_carry_flag_r)
		else $error("zero difference without carry");
endmodule // alu_ops_properties

bind alu_ops_top alu_ops_properties #(.FILE_DEPTH(FILE_DEPTH)) alu_ops_properties_inst (.clk, .resetn, .address, .write,
	.writedata, .waitrequest, .acc_r, .carry_flag_r, .digit_carry_flag_r, .zero_flag_r);

// file: subtract_swap_xor_alu_ops_tb.sv
// testbench for the alu datapath
`timescale 1ns/1ns
`include "alu_ops_regs.vh"
module subtract_swap_xor_alu_ops_tb;
	logic        clk = 0, resetn = 0, read = 0, write = 0, waitrequest, wr;
	logic        carry_flag_r, digit_carry_flag_r, zero_flag_r;
	logic [7:0]  address = 8'h00, acc_r, f, a, k, c, r, s, ad;
	logic [31:0] writedata = 32'h0, readdata, rd;
	int          fails = 0, comparisons = 0;
	// file, acc, literal, ctrl, result, status (preset 3)
	logic [47:0] rows [10] = '{48'h101000000007, 48'h05060004FF00, 48'h200100001F01, 48'hA53300015A03,
		48'hA53300055A03, 48'h15200000F502, 48'h00FFFF020007, 48'h3CC30007FF03, 48'h555500030007,
		48'h000FF006FF03};
	alu_ops_top alu_ops_top_inst (.clk, .resetn, .address, .read, .write, .writedata, .readdata, .waitrequest,
		.acc_r, .carry_flag_r, .digit_carry_flag_r, .zero_flag_r);
	initial begin
		forever #5 clk = ~clk;
	end
	task close_out;
		if (fails == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: %h expected %h", $time, seen, exp);
		end
	endtask
	// one avalon access, held until waitrequest is sampled low
	task bus(input logic w, input logic [7:0] ad_i, input logic [31:0] d);
		int n;
		n = 0;
		address <= ad_i;
		writedata <= d;
		write <= w;
		read <= !w;
		do begin
			@(posedge clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 20);
		rd = readdata;
		if (n >= 20) begin
			fails++;
			close_out;
		end
		read <= 1'b0;
		write <= 1'b0;
		@(posedge clk);
	endtask
	initial begin
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		bus(0, `REG_ACC, 0); chk(rd, `ACC_RESET);
		bus(0, 8'h40, 0); chk(rd, 32'h0);
		for (int i = 0; i < 10; i++) begin
			{f, a, k, c, r, s} = rows[i];
			ad = 8'hFF - i[7:0];
			wr = c[2] && c[1:0] != `OP_XOR_LIT;
			bus(1, ad, {24'h0, f});
			bus(1, `REG_ACC, {24'h0, a});
			bus(1, `REG_STATUS, 32'h3);
			bus(1, `REG_CTRL, {8'h00, k, 1'b0, ad[6:0], c});
			bus(0, `REG_ACC, 0); chk(rd, wr ? a : r);
			bus(0, ad, 0); chk(rd, wr ? r : f);
			bus(0, `REG_STATUS, 0); chk(rd, s);
			chk({zero_flag_r, digit_carry_flag_r, carry_flag_r}, s);
		end
		chk(acc_r, 8'hFF);
		bus(1, `REG_STATUS, 32'h7);
		bus(1, `REG_CTRL, 32'h00007F01);
		bus(0, `REG_STATUS, 0); chk(rd, 32'h7);
		bus(0, `REG_ACC, 0); chk(rd, 32'h01);
		resetn <= 1'b0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		chk(acc_r, `ACC_RESET);
		chk({zero_flag_r, digit_carry_flag_r, carry_flag_r}, `STATUS_RESET);
		bus(0, 8'hFF, 0); chk(rd, 32'h0);
		close_out;
	end
endmodule // subtract_swap_xor_alu_ops_tb
